// ===== ext_io_pkg.sv
// ===========================================================================
// Operation
// - Width field: off, 8-bit, 16-bit, unused
// - Select leads read strobe by 0-7 clocks
// - Select hold after strobe: 0,0,2..7 clocks
// - Read strobe low: 0, 2..7, 8 clocks
// - Latch data write pulses latch strobe
// - Latch access timed by latch timing only
// - Emulation mode: latch strobe drives port-7 latch
// - Window access drives matching select, address, data
// - Windows every 0x40 step; address passed unchanged
// - Windows timed by select timing register only
// - Pin used as plain I/O blocks its bank
// - Control access clears validity; zero disables banks
// - Refresh period is 2049 minus count clocks
// - Refresh enable gates periodic refresh
// - Refresh CAS hold is 1 to 5 clocks
// - Refresh CAS set-up is 1 or 2 clocks
// - Read strobe for all; byte strobes write bytes
// - Byte-select SRAM: lane selects plus write strobe
// - Each window is one register index, four bytes, per 0x40 step
package ext_io_pkg;

   // ========================================================================
   // Register indices; byte address is four times the index.
   localparam logic [13:0] IDX_REFRESH_CTRL = 14'h2020;
   localparam logic [13:0] IDX_SELECT0_WIN = 14'h202C;
   localparam logic [13:0] IDX_SELECT1_WIN = 14'h202E;
   localparam logic [13:0] IDX_LATCH_TIMING = 14'h2030;
   localparam logic [13:0] IDX_SELECT_TIMING = 14'h2034;
   localparam logic [13:0] IDX_STROBE_CFG = 14'h203C;
   localparam logic [13:0] IDX_LATCH_DATA = 14'h203E;
   localparam logic [13:0] IDX_WIN_LAST = 14'h2FEE;
   localparam logic [13:0] IDX_SYSMGR_FIRST = 14'h2000;
   localparam logic [13:0] IDX_SYSMGR_LAST = 14'h203F;

   // ========================================================================
   // Field layout and widths.
   localparam int REFRESH_W = 17;
   localparam int TIMING_W = 14;
   localparam int CFG_W = 2;
   localparam int WIDTH_LSB = 0;
   localparam int SETUP_LSB = 2;
   localparam int HOLD_LSB = 8;
   localparam int ACCESS_LSB = 11;
   localparam int VALID_BIT = 0;
   localparam int RCOUNT_LSB = 1;
   localparam int RCOUNT_W = 11;
   localparam int RENABLE_BIT = 12;
   localparam int CAS_HOLD_LSB = 13;
   localparam int CAS_SETUP_BIT = 16;
   localparam int CFG_BYTE_SEL_BIT = 0;
   localparam int CFG_EMULATION_BIT = 1;
   localparam logic [1:0] WIDTH_OFF = 2'h0;
   localparam logic [1:0] WIDTH_8 = 2'h1;
   localparam logic [1:0] WIDTH_16 = 2'h2;
   localparam logic [11:0] REFRESH_BASE = 12'h801;

   // ========================================================================
   // Reset values.
   localparam logic [REFRESH_W-1:0] REFRESH_RST = 17'h00001;
   localparam logic [TIMING_W-1:0] TIMING_RST = 14'h0000;
   localparam logic [15:0] LATCH_DATA_RST = 16'h0000;
   localparam logic [CFG_W-1:0] CFG_RST = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_ACCESS = 3'h2,
      ST_HOLD = 3'h3,
      ST_DONE = 3'h4
   } xfer_state_e;

   typedef struct packed {
      logic [13:0] addr;
      logic [15:0] data;
      logic data_oe;
      logic [1:0] select_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic byte_write_strobe_lo_n;
      logic byte_write_strobe_hi_n;
      logic latch_write_strobe_n;
   } ext_bus_s;

   typedef struct packed {
      logic [TIMING_W-1:0] timing;
      logic [1:0] sel;
      logic write;
      logic latch;
      logic wide;
      logic [1:0] lanes;
      logic [13:0] addr;
      logic [15:0] data;
   } xfer_ctx_s;

   localparam ext_bus_s EXT_BUS_IDLE = '{addr: 14'h0000, data: 16'h0000,
      data_oe: 1'b0, select_n: 2'h3, read_strobe_n: 1'b1,
      write_strobe_n: 1'b1, byte_write_strobe_lo_n: 1'b1,
      byte_write_strobe_hi_n: 1'b1, latch_write_strobe_n: 1'b1};

   function automatic logic [3:0] setup_clocks(logic [2:0] code);
      return {1'b0, code};
   endfunction : setup_clocks

   function automatic logic [3:0] hold_clocks(logic [2:0] code);
      return (code < 3'h2) ? 4'h0 : {1'b0, code};
   endfunction : hold_clocks

   function automatic logic [3:0] access_clocks(logic [2:0] code);
      return (code == 3'h0) ? 4'h0 : {1'b0, code} + 4'h1;
   endfunction : access_clocks

   // Unused CAS hold codes are clamped to the longest legal hold.
   function automatic logic [2:0] cas_hold_clocks(logic [2:0] code);
      return (code > 3'h4) ? 3'h5 : code + 3'h1;
   endfunction : cas_hold_clocks

endpackage : ext_io_pkg

// ===== ext_io_bank_and_refresh_ctrl.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
module ext_io_bank_and_refresh_ctrl (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pin multiplexing state from the port controller.
   input wire logic bank0_pin_is_io,
   input wire logic bank1_pin_is_io,
   // External bus pins.
   input wire logic [15:0] ext_data_in,
   output ext_io_pkg::ext_bus_s ext_bus,
   // Memory bank and refresh side.
   output logic banks_enable,
   output logic emulation_mode,
   output logic refresh_req,
   output logic refresh_cas_n
);
   import ext_io_pkg::*;

   // ========================================================================
   // Address decode.
   wire logic [13:0] idx = paddr[15:2];
   wire logic setup = psel & ~penable;
   wire logic in_win = (idx >= IDX_SELECT0_WIN) && (idx <= IDX_WIN_LAST);
   wire logic hit_win0 = in_win && idx[5:0] == IDX_SELECT0_WIN[5:0];
   wire logic hit_win1 = in_win && idx[5:0] == IDX_SELECT1_WIN[5:0];
   wire logic hit_refresh = idx == IDX_REFRESH_CTRL;
   wire logic hit_latch_t = idx == IDX_LATCH_TIMING;
   wire logic hit_select_t = idx == IDX_SELECT_TIMING;
   wire logic hit_cfg = idx == IDX_STROBE_CFG;
   wire logic hit_port = idx == IDX_LATCH_DATA;
   wire logic hit_ctrl = hit_refresh | hit_latch_t | hit_select_t | hit_cfg;
   wire logic hit_any = hit_ctrl | hit_port | hit_win0 | hit_win1;

   // ========================================================================
   // Registers.
   logic [REFRESH_W-1:0] refresh_q;
   logic [TIMING_W-1:0] latch_t_q;
   logic [TIMING_W-1:0] select_t_q;
   logic [15:0] port_q;
   logic [CFG_W-1:0] cfg_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] wmask;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign wmask[8*b +: 8] = {8{pstrb[b]}};
      end
   endgenerate

   wire logic commit = psel & penable & pready_q & pwrite & ~pslverr_q;
   wire logic [31:0] wr_refresh = (32'(refresh_q) & ~wmask) | (pwdata & wmask);
   wire logic [31:0] wr_latch_t = (32'(latch_t_q) & ~wmask) | (pwdata & wmask);
   wire logic [31:0] wr_select_t = (32'(select_t_q) & ~wmask) | (pwdata & wmask);
   wire logic [31:0] wr_port = (32'(port_q) & ~wmask) | (pwdata & wmask);
   wire logic [31:0] wr_cfg = (32'(cfg_q) & ~wmask) | (pwdata & wmask);

   // The validity bit is cleared when the setup of any control access is
   // seen, so the final write of a burst can still set it one edge later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_q <= REFRESH_RST;
      end else if (commit && hit_refresh) begin
         refresh_q <= wr_refresh[REFRESH_W-1:0];
      end else if (setup && hit_ctrl) begin
         refresh_q[VALID_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_t_q <= TIMING_RST;
         select_t_q <= TIMING_RST;
         port_q <= LATCH_DATA_RST;
         cfg_q <= CFG_RST;
      end else if (commit) begin
         if (hit_latch_t) latch_t_q <= wr_latch_t[TIMING_W-1:0];
         if (hit_select_t) select_t_q <= wr_select_t[TIMING_W-1:0];
         if (hit_port) port_q <= wr_port[15:0];
         if (hit_cfg) cfg_q <= wr_cfg[CFG_W-1:0];
      end
   end

   wire logic [31:0] rd_reg = hit_refresh ? 32'(refresh_q) :
      hit_latch_t ? 32'(latch_t_q) : hit_select_t ? 32'(select_t_q) :
      hit_port ? 32'(port_q) : hit_cfg ? 32'(cfg_q) : 32'h0;

   // ========================================================================
   // External transfer start and refusal.
   wire logic [1:0] sel_width = select_t_q[WIDTH_LSB +: 2];
   wire logic width_ok = (sel_width == WIDTH_8) || (sel_width == WIDTH_16);
   wire logic win_ok0 = hit_win0 & ~bank0_pin_is_io;
   wire logic win_ok1 = hit_win1 & ~bank1_pin_is_io;
   wire logic win_go = (win_ok0 | win_ok1) & width_ok & refresh_q[VALID_BIT];
   wire logic port_go = hit_port & pwrite;
   wire logic ext_go = setup & (win_go | port_go);
   wire logic refuse = (hit_win0 | hit_win1) & ~win_go;
   wire logic byte_sel = cfg_q[CFG_BYTE_SEL_BIT];

   xfer_state_e state_q, state_d;
   xfer_ctx_s ctx_q, ctx_d, ctx_new;
   logic [3:0] cnt_q, cnt_d;
   ext_bus_s ext_q, ext_d;
   logic [15:0] data_s1_q, data_s2_q, samp_q;
   logic rd1_q, rd2_q;
   // A read may only finish once its last strobed sample has crossed the
   // synchroniser; writes and strobe-less cycles never wait for it.
   wire logic drain = rd1_q | ~ext_q.read_strobe_n;

   wire logic new_wide = port_go ? latch_t_q[WIDTH_LSB +: 2] == WIDTH_16
                                 : sel_width == WIDTH_16;
   always_comb begin
      ctx_new.timing = port_go ? latch_t_q : select_t_q;
      ctx_new.sel = port_go ? 2'h0 : {hit_win1, hit_win0};
      ctx_new.write = pwrite;
      ctx_new.latch = port_go;
      ctx_new.wide = new_wide;
      ctx_new.lanes = !new_wide ? 2'h1 : pwrite ? pstrb[1:0] : 2'h3;
      ctx_new.addr = idx;
      ctx_new.data = pwdata[15:0];
   end
   assign ctx_d = (state_q == ST_IDLE && ext_go) ? ctx_new : ctx_q;

   wire logic [3:0] su = setup_clocks(ctx_d.timing[SETUP_LSB +: 3]);
   wire logic [3:0] ho = hold_clocks(ctx_d.timing[HOLD_LSB +: 3]);
   wire logic [3:0] ac = access_clocks(ctx_d.timing[ACCESS_LSB +: 3]);

   // Each phase lasts its count; a phase of zero clocks is skipped.
   always_comb begin
      logic adv;
      logic [1:0] from;
      adv = 1'b0;
      from = 2'h0;
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         ST_IDLE: begin
            adv = ext_go;
         end
         ST_SETUP: begin
            adv = cnt_q <= 4'h1;
            from = 2'h1;
         end
         ST_ACCESS: begin
            adv = cnt_q <= 4'h1;
            from = 2'h2;
         end
         ST_HOLD: begin
            adv = cnt_q <= 4'h1;
            from = 2'h3;
         end
         ST_DONE: begin
            state_d = (pready_q || !drain) ? ST_IDLE : ST_DONE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (!adv && state_q != ST_IDLE && state_q != ST_DONE) begin
         cnt_d = cnt_q - 4'h1;
      end else if (adv) begin
         if (from == 2'h0 && su != 4'h0) begin
            state_d = ST_SETUP;
            cnt_d = su;
         end else if (from <= 2'h1 && ac != 4'h0) begin
            state_d = ST_ACCESS;
            cnt_d = ac;
         end else if (from <= 2'h2 && ho != 4'h0) begin
            state_d = ST_HOLD;
            cnt_d = ho;
         end else begin
            state_d = ST_DONE;
         end
      end
   end

   // ========================================================================
   // Pin values follow the next state so every pin leaves a flip-flop.
   wire logic cyc = state_d inside {ST_SETUP, ST_ACCESS, ST_HOLD};
   wire logic acc = state_d == ST_ACCESS;
   wire logic dev = cyc & ~ctx_d.latch;
   wire logic wr_acc = acc & ctx_d.write;
   always_comb begin
      ext_d = ext_q;
      ext_d.addr = ctx_d.addr;
      ext_d.data = ctx_d.data;
      ext_d.data_oe = cyc & ctx_d.write;
      ext_d.select_n = dev ? ~ctx_d.sel : 2'h3;
      ext_d.read_strobe_n = ~(acc & dev & ~ctx_d.write);
      ext_d.latch_write_strobe_n = ~(wr_acc & ctx_d.latch);
      ext_d.write_strobe_n = ~(wr_acc & dev & byte_sel);
      if (byte_sel) begin
         ext_d.byte_write_strobe_lo_n = ~(dev & ctx_d.lanes[0]);
         ext_d.byte_write_strobe_hi_n = ~(dev & ctx_d.lanes[1]);
      end else begin
         ext_d.byte_write_strobe_lo_n = ~(wr_acc & dev & ctx_d.lanes[0]);
         ext_d.byte_write_strobe_hi_n = ~(wr_acc & dev & ctx_d.lanes[1]);
      end
   end

   // Read data lags the pins by the two synchroniser stages, so the strobe
   // is delayed alongside it and only strobed samples are kept.
   wire logic [15:0] samp_d = rd2_q ? data_s2_q : samp_q;
   wire logic [15:0] rd_ext = ctx_q.wide ? samp_d : {8'h00, samp_d[7:0]};
   wire logic fin = !drain && ((state_d == ST_DONE && state_q != ST_DONE) ||
      (state_q == ST_DONE && !pready_q));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         ctx_q <= '0;
         ext_q <= EXT_BUS_IDLE;
         data_s1_q <= 16'h0000;
         data_s2_q <= 16'h0000;
         samp_q <= 16'h0000;
         rd1_q <= 1'b0;
         rd2_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ctx_q <= ctx_d;
         ext_q <= ext_d;
         data_s1_q <= ext_data_in;
         data_s2_q <= data_s1_q;
         samp_q <= samp_d;
         rd1_q <= ~ext_q.read_strobe_n;
         rd2_q <= rd1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= (setup & ~ext_go) | fin;
         pslverr_q <= setup & (~hit_any | refuse);
         if (setup && !ext_go) begin
            prdata_q <= pwrite ? 32'h0 : rd_reg;
         end else if (fin) begin
            prdata_q <= ctx_q.write ? 32'h0 : 32'(rd_ext);
         end
      end
   end

   // ========================================================================
   // Refresh interval and CAS sequence.
   wire logic ren = refresh_q[RENABLE_BIT];
   wire logic [11:0] period = REFRESH_BASE - 12'(refresh_q[RCOUNT_LSB +: RCOUNT_W]);
   logic [11:0] rcnt_q;
   wire logic tick = ren && rcnt_q == 12'h001;
   logic [1:0] rsu_q;
   logic [2:0] rh_q;
   logic [2:0] rh_d;
   logic emu_q, req_q, cas_n_q;

   always_comb begin
      rh_d = (rh_q != 3'h0) ? rh_q - 3'h1 : 3'h0;
      if (rsu_q == 2'h1) begin
         rh_d = cas_hold_clocks(refresh_q[CAS_HOLD_LSB +: 3]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcnt_q <= 12'h000;
         rsu_q <= 2'h0;
         rh_q <= 3'h0;
         req_q <= 1'b0;
         cas_n_q <= 1'b1;
         emu_q <= 1'b0;
      end else begin
         // Enabling starts from zero so that a freshly written count is
         // loaded at once instead of the stale one.
         rcnt_q <= !ren ? 12'h000 : (tick || rcnt_q == 12'h000) ? period :
                  rcnt_q - 12'h001;
         req_q <= tick;
         rsu_q <= tick ? 2'(refresh_q[CAS_SETUP_BIT]) + 2'h1 :
                  (rsu_q != 2'h0) ? rsu_q - 2'h1 : 2'h0;
         rh_q <= rh_d;
         cas_n_q <= rh_d == 3'h0;
         emu_q <= cfg_q[CFG_EMULATION_BIT];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ext_bus = ext_q;
   assign banks_enable = refresh_q[VALID_BIT];
   assign emulation_mode = emu_q;
   assign refresh_req = req_q;
   assign refresh_cas_n = cas_n_q;

   // ========================================================================
   // Assertions and the counters that only they read.
   logic [3:0] pre_q, low_q;
   logic [11:0] gap_q;
   logic seen_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 4'h0;
         low_q <= 4'h0;
         gap_q <= 12'h000;
         seen_q <= 1'b0;
      end else begin
         pre_q <= (&ext_q.select_n) ? 4'h0 : pre_q + 4'(ext_q.read_strobe_n);
         low_q <= ext_q.read_strobe_n ? 4'h0 : low_q + 4'h1;
         gap_q <= req_q ? 12'h001 : gap_q + 12'h001;
         seen_q <= (req_q | seen_q) & ren & ~(commit & hit_refresh);
      end
   end

   sequence s_cas_one;
      refresh_cas_n ##1 !refresh_cas_n ##1 refresh_cas_n;
   endsequence

   a_width_refused: assert property (@(posedge pclk) disable iff (!presetn)
      setup && hit_win0 && sel_width == WIDTH_OFF |=> pready && pslverr)
      else $error("disabled bank was not refused");
   a_setup_clocks: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ext_bus.read_strobe_n) |-> pre_q == su)
      else $error("select set-up count wrong");
   a_access_clocks: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ext_bus.read_strobe_n) |-> low_q == ac)
      else $error("read strobe low time wrong");
   a_latch_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      setup && port_go && latch_t_q[ACCESS_LSB +: 3] != 3'h0 |->
      ##[1:30] (!ext_bus.latch_write_strobe_n && ext_bus.data_oe))
      else $error("latch write gave no strobe");
   a_latch_no_select: assert property (@(posedge pclk) disable iff (!presetn)
      !ext_bus.latch_write_strobe_n |-> ext_bus.select_n == 2'h3)
      else $error("select driven during latch write");
   a_select_address: assert property (@(posedge pclk) disable iff (!presetn)
      !ext_bus.select_n[0] |-> ext_bus.addr[5:0] == IDX_SELECT0_WIN[5:0])
      else $error("select 0 with foreign address");
   a_pin_io_block: assert property (@(posedge pclk) disable iff (!presetn)
      setup && hit_win1 && bank1_pin_is_io |=> pslverr ##1 state_q == ST_IDLE)
      else $error("bank used while its pin is plain I/O");
   a_valid_clear: assert property (@(posedge pclk) disable iff (!presetn)
      setup && hit_latch_t |=> !banks_enable)
      else $error("validity not cleared on control access");
   a_refresh_period: assert property (@(posedge pclk) disable iff (!presetn)
      refresh_req && seen_q && $stable(period) |-> gap_q == period)
      else $error("refresh period wrong");
   a_refresh_off: assert property (@(posedge pclk) disable iff (!presetn)
      !ren |=> !refresh_req)
      else $error("refresh request while disabled");
   a_cas_shortest: assert property (@(posedge pclk) disable iff (!presetn)
      refresh_req && rsu_q == 2'h1 && refresh_q[CAS_HOLD_LSB +: 3] == 3'h0
      |-> s_cas_one)
      else $error("refresh CAS timing wrong");
   a_strobe_in_select: assert property (@(posedge pclk) disable iff (!presetn)
      !ext_bus.read_strobe_n |-> ext_bus.select_n != 2'h3)
      else $error("read strobe outside select");

endmodule : ext_io_bank_and_refresh_ctrl

// ===== ext_io_dev_model.sv
`timescale 1ns/1ps
module ext_io_dev_model (
   // Clock.
   input wire logic pclk,
   // Pins from the controller.
   input ext_io_pkg::ext_bus_s ext_bus,
   // Data lines back to the controller.
   output logic [15:0] ext_data_in
);
   import ext_io_pkg::*;

   // ========================================================================
   // Observation state, read by the bench after each transfer.
   logic [15:0] last_q = 16'h0000;
   logic act_q = 1'b0;
   logic lat_q = 1'b1;
   logic on_sel;
   logic seen, lo, hi, we;
   logic [1:0] sel;
   logic [13:0] adr;
   logic [15:0] wdat, ldat;
   int lead, stb, hld, lat;

   assign on_sel = ext_bus.select_n != 2'h3;
   // Undriven lines show the inverse of their last value, so that stale
   // data can never pass for a fresh read.
   assign ext_data_in = (on_sel && !ext_bus.read_strobe_n) ?
      ({2'h0, ext_bus.addr} ^ 16'h5A5A) : ~last_q;

   // ========================================================================
   // Cycle phase counting.
   always @(posedge pclk) begin
      last_q <= ext_data_in;
      act_q <= on_sel;
      lat_q <= ext_bus.latch_write_strobe_n;
      if (on_sel && !act_q) begin
         {lead, stb, hld} = '0;
         {seen, lo, hi, we} = 4'h0;
      end
      if (on_sel) begin
         sel = ~ext_bus.select_n;
         adr = ext_bus.addr;
         if (!ext_bus.read_strobe_n) begin
            stb++;
            seen = 1'b1;
         end else if (seen) hld++;
         else lead++;
         lo |= !ext_bus.byte_write_strobe_lo_n;
         hi |= !ext_bus.byte_write_strobe_hi_n;
         we |= !ext_bus.write_strobe_n;
         if (ext_bus.data_oe) wdat = ext_bus.data;
      end
      if (!ext_bus.latch_write_strobe_n) begin
         if (lat_q) lat = 0;
         lat++;
      end else if (!lat_q) ldat = ext_bus.data;
   end
endmodule : ext_io_dev_model

// ===== ext_io_bank_and_refresh_ctrl_tb_top.sv
`timescale 1ns/1ps
module ext_io_bank_and_refresh_ctrl_tb_top;
   import ext_io_pkg::*;
   localparam logic [15:0] A_RF = {IDX_REFRESH_CTRL, 2'b00};
   localparam logic [15:0] A_W0 = {14'h206C, 2'b00};
   localparam logic [15:0] A_W1 = {IDX_SELECT1_WIN, 2'b00};
   localparam logic [15:0] A_LT = {IDX_LATCH_TIMING, 2'b00};
   localparam logic [15:0] A_ST = {IDX_SELECT_TIMING, 2'b00};
   localparam logic [15:0] A_CF = {IDX_STROBE_CFG, 2'b00};
   localparam logic [15:0] A_LD = {IDX_LATCH_DATA, 2'b00};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic bank0_pin_is_io, bank1_pin_is_io, banks_enable, emulation_mode;
   logic refresh_req, refresh_cas_n;
   logic [15:0] paddr, ext_data_in;
   logic [31:0] pwdata, prdata, q, rf;
   logic [3:0] pstrb;
   ext_bus_s ext_bus;
   int failures = 0, checked = 0, cyc = 0, n, m, f;

   ext_io_bank_and_refresh_ctrl uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bank0_pin_is_io(bank0_pin_is_io),
      .bank1_pin_is_io(bank1_pin_is_io), .ext_data_in(ext_data_in),
      .ext_bus(ext_bus), .banks_enable(banks_enable),
      .emulation_mode(emulation_mode), .refresh_req(refresh_req),
      .refresh_cas_n(refresh_cas_n));
   ext_io_dev_model dev (.pclk(pclk), .ext_bus(ext_bus),
      .ext_data_in(ext_data_in));

   // ========================================================================
   // Shared tasks.
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; checks the wait count and the error response.
   task automatic op(input logic w, input logic [15:0] a,
      input logic [31:0] d, input logic [3:0] s, input int lx,
      input logic ex);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(k, lx);
      chk(e, ex);
   endtask : op

   // Control writes drop validity, so each ends with the refresh control.
   task automatic set(input logic [15:0] a, input logic [31:0] v);
      op(1'b1, a, v, 4'hF, 1, 1'b0);
      op(1'b1, A_RF, rf, 4'hF, 1, 1'b0);
   endtask : set

   function automatic logic [31:0] tm(input logic [2:0] c,
      input logic [1:0] w);
      return {18'h0, c, c, 3'h0, c, w};
   endfunction : tm

   always #2 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end

   // ========================================================================
   // Main sequence.
   initial begin
      {pclk, presetn, psel, penable, pwrite} = 5'h0;
      {paddr, pwdata, pstrb, bank0_pin_is_io, bank1_pin_is_io} = '0;
      rf = 32'h00000001;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      chk(banks_enable, 1);
      op(1'b0, A_LT, 0, 4'hF, 1, 1'b0);
      chk(q, 0);
      chk(banks_enable, 0);
      op(1'b0, A_ST, 0, 4'hF, 1, 1'b0);
      chk(q, 0);
      op(1'b0, A_LD, 0, 4'hF, 1, 1'b0);
      chk(q, 0);
      op(1'b0, A_W0, 0, 4'hF, 1, 1'b1);
      op(1'b1, 16'h1000, 32'h1234, 4'hF, 1, 1'b1);
      op(1'b1, A_RF, rf, 4'hF, 1, 1'b0);
      @(negedge pclk);
      chk(banks_enable, 1);
      op(1'b0, A_W0, 0, 4'hF, 1, 1'b1);
      for (int c = 1; c < 8; c++) begin
         set(A_ST, tm(3'(c), 2'h2));
         op(1'b0, A_W0, 0, 4'hF, c < 2 ? 6 : 3 * c + 2, 1'b0);
         @(negedge pclk);
         chk(dev.lead, c);
         chk(dev.stb, c + 1);
         chk(dev.hld, c < 2 ? 0 : c);
         chk(q[15:0], 16'h7A36);
         chk(dev.adr, 14'h206C);
         chk(dev.sel, 2'h1);
      end
      op(1'b1, A_W1, 32'hBEEF, 4'h3, 23, 1'b0);
      @(negedge pclk);
      chk({dev.sel, dev.adr}, {2'h2, IDX_SELECT1_WIN});
      chk({dev.wdat, dev.lo, dev.hi, dev.we}, {16'hBEEF, 3'h6});
      set(A_ST, tm(3'h1, 2'h1));
      op(1'b0, A_W0, 0, 4'hF, 6, 1'b0);
      chk(q[15:0], 16'h0036);
      op(1'b1, A_W0, 32'h1234, 4'h3, 4, 1'b0);
      @(negedge pclk);
      chk({dev.wdat[7:0], dev.lo, dev.hi}, {8'h34, 2'h2});
      set(A_ST, tm(3'h1, 2'h2));
      set(A_CF, 32'h1);
      op(1'b1, A_W0, 32'h5500, 4'h2, 4, 1'b0);
      @(negedge pclk);
      chk({dev.lo, dev.hi, dev.we}, 3'h3);
      bank0_pin_is_io <= 1'b1;
      op(1'b0, A_W0, 0, 4'hF, 1, 1'b1);
      op(1'b0, A_W1, 0, 4'hF, 6, 1'b0);
      {bank0_pin_is_io, bank1_pin_is_io} <= 2'b01;
      op(1'b0, A_W1, 0, 4'hF, 1, 1'b1);
      bank1_pin_is_io <= 1'b0;
      set(A_LT, {18'h0, 3'h3, 9'h0, 2'h2});
      set(A_CF, 32'h2);
      chk(emulation_mode, 1);
      op(1'b1, A_LD, 32'hFF, 4'hF, 5, 1'b0);
      @(negedge pclk);
      chk({dev.lat, dev.ldat}, {32'd4, 16'h00FF});
      op(1'b0, A_LD, 0, 4'hF, 1, 1'b0);
      chk(q, 32'hFF);
      for (int i = 0; i < 2; i++) begin
         rf = i ? 32'h00001FE1 : 32'h00015FE1;
         op(1'b1, A_RF, rf, 4'hF, 1, 1'b0);
         n = 0;
         while (refresh_req !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
         end
         {n, m, f} = '0;
         do begin
            @(posedge pclk);
            n++;
            if (refresh_cas_n === 1'b0) begin
               if (m == 0) f = n;
               m++;
            end
         end while (refresh_req !== 1'b1 && n < 100);
         chk(n, 17);
         chk(m, i ? 1 : 3);
         chk(f, i ? 1 : 2);
         rf = 32'h00000001;
         op(1'b1, A_RF, rf, 4'hF, 1, 1'b0);
      end
      repeat (3) @(posedge pclk);
      m = 0;
      repeat (40) begin
         @(posedge pclk);
         if (refresh_req === 1'b1) m++;
      end
      chk(m, 0);
      end_of_test();
   end
endmodule : ext_io_bank_and_refresh_ctrl_tb_top
